// ==== src/cmp_pkg.sv ====
// Package: special-function addresses, field positions and reset values for the comparators
package cmp_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CMP0_CTRL_ADDR = 8'h9b;
  localparam logic [7:0] CMP1_CTRL_ADDR = 8'h9a;
  localparam logic [7:0] CMP0_MODE_ADDR = 8'h9d;
  localparam logic [7:0] CMP1_MODE_ADDR = 8'h9c;
  localparam logic [7:0] CMP0_MUX_ADDR = 8'h9f;
  localparam logic [7:0] CMP1_MUX_ADDR = 8'h9e;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OUT_BIT = 6;
  localparam int CTRL_RISE_BIT = 5;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_HYP_LSB = 2;
  localparam int CTRL_HYN_LSB = 0;
  localparam int MODE_RIE_BIT = 5;
  localparam int MODE_FIE_BIT = 4;
  localparam int MODE_RESP_LSB = 0;
  localparam int MUX_NEG_LSB = 4;
  localparam int MUX_POS_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h02;
  localparam logic [7:0] MUX_RESET = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h33;
  localparam logic [7:0] MUX_WMASK = 8'h33;

  // Hysteresis field encodings
  typedef enum logic [1:0] {
    HYST_OFF = 2'b00,
    HYST_5MV = 2'b01,
    HYST_10MV = 2'b10,
    HYST_20MV = 2'b11
  } hyst_t;

endpackage

// ==== src/cmp_sync.sv ====
// Two-flop synchroniser for the raw comparator output
`timescale 1ns/10ps
module cmp_sync (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;

  // First flop feeds only the second
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // cmp_sync

// ==== src/cmp_channel.sv ====
// One comparator channel: control, mode and mux registers, flags and outputs
`timescale 1ns/10ps
module cmp_channel
  import cmp_pkg::*;
#(
  parameter logic [7:0] CTRL_ADDR = 8'h00,
  parameter logic [7:0] MODE_ADDR = 8'h00,
  parameter logic [7:0] MUX_ADDR = 8'h00
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_analog_out,
  output logic o_hit,
  output logic [7:0] o_rdata,
  output logic o_enable,
  output logic [1:0] o_pos_hyst,
  output logic [1:0] o_neg_hyst,
  output logic [1:0] o_resp_mode,
  output logic [1:0] o_pos_sel,
  output logic [1:0] o_neg_sel,
  output logic o_raw_out,
  output logic o_latched_out,
  output logic o_rise_flag,
  output logic o_fall_flag,
  output logic o_rise_irq_en,
  output logic o_fall_irq_en
);
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] mode_q;
  logic [7:0] mux_q;
  logic sync_out;
  logic prev_q;
  wire wr_ctrl = i_sfr_wr && (i_sfr_addr == CTRL_ADDR);
  wire wr_mode = i_sfr_wr && (i_sfr_addr == MODE_ADDR);
  wire wr_mux = i_sfr_wr && (i_sfr_addr == MUX_ADDR);
  wire rise_evt = sync_out & ~prev_q;
  wire fall_evt = ~sync_out & prev_q;

  // Raw output passes through two flops of the core clock to form the latched output
  cmp_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_async(o_raw_out),
    .o_sync(sync_out)
  );

  // Flag updates: hardware set wins over a software clear
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = i_sfr_wdata;
    end
    ctrl_d[CTRL_OUT_BIT] = 1'b0; // Output bit is read-only
    if (rise_evt) begin
      ctrl_d[CTRL_RISE_BIT] = 1'b1;
    end
    if (fall_evt) begin
      ctrl_d[CTRL_FALL_BIT] = 1'b1;
    end
  end

  // Register storage
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ctrl_q <= CTRL_RESET;
      mode_q <= MODE_RESET;
      mux_q <= MUX_RESET;
      prev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      prev_q <= sync_out;
      if (wr_mode) begin
        mode_q <= i_sfr_wdata & MODE_WMASK;
      end
      if (wr_mux) begin
        mux_q <= i_sfr_wdata & MUX_WMASK;
      end
    end
  end

  // Field decode and outputs
  assign o_enable = ctrl_q[CTRL_EN_BIT];
  assign o_pos_hyst = ctrl_q[CTRL_HYP_LSB +: 2];
  assign o_neg_hyst = ctrl_q[CTRL_HYN_LSB +: 2];
  assign o_resp_mode = mode_q[MODE_RESP_LSB +: 2];
  assign o_pos_sel = mux_q[MUX_POS_LSB +: 2];
  assign o_neg_sel = mux_q[MUX_NEG_LSB +: 2];
  assign o_rise_irq_en = mode_q[MODE_RIE_BIT];
  assign o_fall_irq_en = mode_q[MODE_FIE_BIT];
  assign o_rise_flag = ctrl_q[CTRL_RISE_BIT];
  assign o_fall_flag = ctrl_q[CTRL_FALL_BIT];
  assign o_raw_out = i_analog_out & o_enable;
  assign o_latched_out = sync_out;
  assign o_hit = (i_sfr_addr == CTRL_ADDR) || (i_sfr_addr == MODE_ADDR)
                 || (i_sfr_addr == MUX_ADDR);

  // Read data: output state shows the synchronised value
  always_comb begin
    o_rdata = 8'h00;
    if (i_sfr_addr == CTRL_ADDR) begin
      o_rdata = ctrl_q;
      o_rdata[CTRL_OUT_BIT] = sync_out;
    end else if (i_sfr_addr == MODE_ADDR) begin
      o_rdata = mode_q;
    end else if (i_sfr_addr == MUX_ADDR) begin
      o_rdata = mux_q;
    end
  end
endmodule // cmp_channel

// ==== src/dual_comparator_control.sv ====
// Top: two comparator channels on the special-function register port
// What this block does
// - Two identical comparators; differ in input pins and only comparator 0 can request a reset.
// - Each gives a clock-latched output and a raw output working without clock.
// - Two-bit positive and negative input selects per comparator in its mux register.
// - Disabled comparator drives its pin output low.
// - Writable two-bit response-time mode per comparator; slower uses less current.
// - Control bits 3..0 hold hysteresis; upper pair positive, lower pair negative.
// - Hysteresis codes 00 off, 01 5 mV, 10 10 mV, 11 20 mV.
// - Positive and negative hysteresis set independently.
// - Interrupt events on both rising and falling output transitions.
// - Falling transition sets falling flag, control bit 4.
// - Rising transition sets rising flag, control bit 5.
// - Edge flags stay set until software writes zero.
// - Control bit 6 reads current output, 1 when plus above minus.
// - Control bit 7 enables comparator when 1, disables when 0.
// - Comparator 0 control sits at address 0x9B, resetting to zero.
// - Comparator 0 output offered as a reset request source.
`timescale 1ns/10ps
module dual_comparator_control
  import cmp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  input wire logic i_cmp0_analog,
  input wire logic i_cmp1_analog,
  input wire logic i_cmp0_reset_en,
  output logic o_cmp0_enable,
  output logic o_cmp1_enable,
  output logic [1:0] o_cmp0_pos_hyst,
  output logic [1:0] o_cmp0_neg_hyst,
  output logic [1:0] o_cmp1_pos_hyst,
  output logic [1:0] o_cmp1_neg_hyst,
  output logic [1:0] o_cmp0_resp_mode,
  output logic [1:0] o_cmp1_resp_mode,
  output logic [1:0] o_cmp0_pos_input_sel,
  output logic [1:0] o_cmp0_neg_input_sel,
  output logic [1:0] o_cmp1_pos_input_sel,
  output logic [1:0] o_cmp1_neg_input_sel,
  output logic o_cmp0_raw_out,
  output logic o_cmp1_raw_out,
  output logic o_cmp0_latched_out,
  output logic o_cmp1_latched_out,
  output logic o_cmp0_rise_flag,
  output logic o_cmp0_fall_flag,
  output logic o_cmp1_rise_flag,
  output logic o_cmp1_fall_flag,
  output logic o_cmp0_irq,
  output logic o_cmp1_irq,
  output logic o_cmp0_reset_req
);
  import cmp_pkg::*;

  // ----------------------------------------------------------------
  // Channel instances
  // ----------------------------------------------------------------
  logic hit0;
  logic hit1;
  logic [7:0] rd0;
  logic [7:0] rd1;
  logic rie0;
  logic fie0;
  logic rie1;
  logic fie1;

  // Comparator 0 (control at 0x9B), identical logic to comparator 1
  cmp_channel #(
    .CTRL_ADDR(CMP0_CTRL_ADDR),
    .MODE_ADDR(CMP0_MODE_ADDR),
    .MUX_ADDR(CMP0_MUX_ADDR)
  ) u_cmp0 (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata),
    .i_analog_out(i_cmp0_analog),
    .o_hit(hit0),
    .o_rdata(rd0),
    .o_enable(o_cmp0_enable),
    .o_pos_hyst(o_cmp0_pos_hyst),
    .o_neg_hyst(o_cmp0_neg_hyst),
    .o_resp_mode(o_cmp0_resp_mode),
    .o_pos_sel(o_cmp0_pos_input_sel),
    .o_neg_sel(o_cmp0_neg_input_sel),
    .o_raw_out(o_cmp0_raw_out),
    .o_latched_out(o_cmp0_latched_out),
    .o_rise_flag(o_cmp0_rise_flag),
    .o_fall_flag(o_cmp0_fall_flag),
    .o_rise_irq_en(rie0),
    .o_fall_irq_en(fie0)
  );

  // Comparator 1, same behaviour, its own pins and addresses
  cmp_channel #(
    .CTRL_ADDR(CMP1_CTRL_ADDR),
    .MODE_ADDR(CMP1_MODE_ADDR),
    .MUX_ADDR(CMP1_MUX_ADDR)
  ) u_cmp1 (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata),
    .i_analog_out(i_cmp1_analog),
    .o_hit(hit1),
    .o_rdata(rd1),
    .o_enable(o_cmp1_enable),
    .o_pos_hyst(o_cmp1_pos_hyst),
    .o_neg_hyst(o_cmp1_neg_hyst),
    .o_resp_mode(o_cmp1_resp_mode),
    .o_pos_sel(o_cmp1_pos_input_sel),
    .o_neg_sel(o_cmp1_neg_input_sel),
    .o_raw_out(o_cmp1_raw_out),
    .o_latched_out(o_cmp1_latched_out),
    .o_rise_flag(o_cmp1_rise_flag),
    .o_fall_flag(o_cmp1_fall_flag),
    .o_rise_irq_en(rie1),
    .o_fall_irq_en(fie1)
  );

  // ----------------------------------------------------------------
  // Read mux, interrupt requests and reset source
  // ----------------------------------------------------------------
  assign o_sfr_hit = hit0 | hit1;
  assign o_sfr_rdata = hit0 ? rd0 : (hit1 ? rd1 : 8'h00);
  // Flag levels gated by their enables toward the interrupt handler
  assign o_cmp0_irq = (o_cmp0_rise_flag & rie0) | (o_cmp0_fall_flag & fie0);
  assign o_cmp1_irq = (o_cmp1_rise_flag & rie1) | (o_cmp1_fall_flag & fie1);
  // Only comparator 0 can request a reset; asserted while reset enable and comparator enable are set and the latched output is low
  assign o_cmp0_reset_req = i_cmp0_reset_en & o_cmp0_enable & ~o_cmp0_latched_out;

endmodule // dual_comparator_control

// ==== dv/cmp_analog_model.sv ====
// Behavioural model of one analog comparator core
`timescale 1ns/10ps
module cmp_analog_model (
  input wire logic [9:0] i_plus_mv,
  input wire logic [9:0] i_minus_mv,
  output logic o_decision
);
  // High while plus input exceeds minus input
  assign o_decision = (i_plus_mv > i_minus_mv);
endmodule // cmp_analog_model

// ==== dv/dual_comparator_control_asserts.sv ====
// Port checks for comparator 0 of the dual comparator block
`timescale 1ns/10ps
module dual_comparator_control_asserts
  import cmp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_cmp0_analog,
  input wire logic i_cmp0_reset_en,
  input wire logic o_cmp0_enable,
  input wire logic [1:0] o_cmp0_pos_hyst,
  input wire logic [1:0] o_cmp0_neg_hyst,
  input wire logic o_cmp0_raw_out,
  input wire logic o_cmp0_latched_out,
  input wire logic o_cmp0_rise_flag,
  input wire logic o_cmp0_fall_flag,
  input wire logic o_cmp0_reset_req
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // Control write and rise/fall-flag clears
  wire clr_r = i_sfr_wr && i_sfr_addr == CMP0_CTRL_ADDR && !i_sfr_wdata[5];
  wire clr_f = i_sfr_wr && i_sfr_addr == CMP0_CTRL_ADDR && !i_sfr_wdata[4];
  sequence s_wr;
    i_sfr_wr && i_sfr_addr == CMP0_CTRL_ADDR;
  endsequence
  sequence s_rise;
    $rose(o_cmp0_latched_out);
  endsequence
  // ----
  // Checks
  // ----
  property p_raw;
    o_cmp0_raw_out == (i_cmp0_analog && o_cmp0_enable);
  endproperty
  a_raw: assert property (p_raw) else $error("raw out");
  property p_sync;
    o_cmp0_latched_out == $past(o_cmp0_raw_out, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("latched out");
  property p_rise;
    s_rise |=> o_cmp0_rise_flag;
  endproperty
  a_rise: assert property (p_rise) else $error("rise flag");
  property p_fall;
    $fell(o_cmp0_latched_out) |=> o_cmp0_fall_flag;
  endproperty
  a_fall: assert property (p_fall) else $error("fall flag");
  property p_keep;
    o_cmp0_rise_flag && !clr_r |=> o_cmp0_rise_flag;
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_keep_f;
    o_cmp0_fall_flag && !clr_f |=> o_cmp0_fall_flag;
  endproperty
  a_keep_f: assert property (p_keep_f) else $error("fall flag lost");
  property p_read;
    i_sfr_addr == CMP0_CTRL_ADDR |-> o_sfr_rdata == {o_cmp0_enable, o_cmp0_latched_out,
      o_cmp0_rise_flag, o_cmp0_fall_flag, o_cmp0_pos_hyst, o_cmp0_neg_hyst};
  endproperty
  a_read: assert property (p_read) else $error("ctrl read");
  property p_en;
    s_wr |=> o_cmp0_enable == $past(i_sfr_wdata[7]);
  endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_hyst;
    s_wr |=> {o_cmp0_pos_hyst, o_cmp0_neg_hyst} == $past(i_sfr_wdata[3:0]);
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis");
  property p_rst;
    o_cmp0_reset_req == (i_cmp0_reset_en && o_cmp0_enable && !o_cmp0_latched_out);
  endproperty
  a_rst: assert property (p_rst) else $error("reset req");
endmodule // dual_comparator_control_asserts
bind dual_comparator_control dual_comparator_control_asserts i_chk (.*);

// ==== dv/dual_comparator_control_test.sv ====
// Self-checking bench for the dual comparator block
`timescale 1ns/10ps
module dual_comparator_control_test;
  import cmp_pkg::*;
  logic clk = 0, srst = 1, wr = 0, hit, rq, nd, ren = 1;
  logic [7:0] addr = 8'h00, wd = 8'h00, rd, v;
  logic [1:0][7:0] cm = '0, md = {MODE_RESET, MODE_RESET};
  logic [1:0][9:0] pl = '0, mi = '0;
  logic [1:0][1:0] ph, nh, rm, ps, ns;
  logic [1:0] an, en, raw, lat, rf, ff, irq, lm = '0, rfm = '0, ffm = '0;
  logic [7:0] ca [2] = '{CMP0_CTRL_ADDR, CMP1_CTRL_ADDR};
  logic [7:0] ma [2] = '{CMP0_MODE_ADDR, CMP1_MODE_ADDR};
  logic [7:0] xa [2] = '{CMP0_MUX_ADDR, CMP1_MUX_ADDR};
  int seed = 94, error_cnt = 0, n_checks = 0;
  // Clock and analog cores
  initial forever #10 clk = ~clk;
  for (genvar g = 0; g < 2; g++) begin : g_an
    cmp_analog_model i_cmp_analog_model (.i_plus_mv(pl[g]), .i_minus_mv(mi[g]),
      .o_decision(an[g]));
  end
  dual_comparator_control i_dual_comparator_control (.i_core_clk(clk), .i_srst(srst),
    .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wd), .o_sfr_rdata(rd), .o_sfr_hit(hit),
    .i_cmp0_analog(an[0]), .i_cmp1_analog(an[1]), .i_cmp0_reset_en(ren),
    .o_cmp0_enable(en[0]), .o_cmp1_enable(en[1]), .o_cmp0_pos_hyst(ph[0]),
    .o_cmp0_neg_hyst(nh[0]), .o_cmp1_pos_hyst(ph[1]), .o_cmp1_neg_hyst(nh[1]),
    .o_cmp0_resp_mode(rm[0]), .o_cmp1_resp_mode(rm[1]), .o_cmp0_pos_input_sel(ps[0]),
    .o_cmp0_neg_input_sel(ns[0]), .o_cmp1_pos_input_sel(ps[1]),
    .o_cmp1_neg_input_sel(ns[1]), .o_cmp0_raw_out(raw[0]), .o_cmp1_raw_out(raw[1]),
    .o_cmp0_latched_out(lat[0]), .o_cmp1_latched_out(lat[1]), .o_cmp0_rise_flag(rf[0]),
    .o_cmp0_fall_flag(ff[0]), .o_cmp1_rise_flag(rf[1]), .o_cmp1_fall_flag(ff[1]),
    .o_cmp0_irq(irq[0]), .o_cmp1_irq(irq[1]), .o_cmp0_reset_req(rq));
  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    @(negedge clk);
    chk("rdata", rd, e);
  endtask
  function automatic logic [7:0] ectl(int c);
    return {cm[c][7], lm[c], rfm[c], ffm[c], cm[c][3:0]};
  endfunction
  // Let the synchroniser settle, then update the model and compare
  task automatic step(int c);
    repeat (4) @(posedge clk);
    nd = cm[c][7] && pl[c] > mi[c];
    rfm[c] = rfm[c] | (nd & !lm[c]);
    ffm[c] = ffm[c] | (!nd & lm[c]);
    lm[c] = nd;
    @(negedge clk);
    chk("raw", raw[c], nd);
    chk("lat", lat[c], nd);
    if (c == 0) chk("rq", rq, ren && cm[0][7] && !nd);
    chk("irq", irq[c], (rfm[c] & md[c][MODE_RIE_BIT])
      | (ffm[c] & md[c][MODE_FIE_BIT]));
    rdc(ca[c], ectl(c));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  // Main sequence, both channels alike
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      rdc(ca[c], CTRL_RESET);
      rdc(ma[c], MODE_RESET);
      rdc(xa[c], MUX_RESET);
      for (int h = 0; h < 16; h++) begin
        cm[c] = 8'h80 | h[7:0];
        wrt(ca[c], cm[c] | 8'h40);
        rdc(ca[c], ectl(c));
        chk("hyst", {ph[c], nh[c]}, h[7:0]);
      end
      for (int m = 0; m < 4; m++) begin
        v = 8'($random(seed));
        v[1:0] = m[1:0];
        wrt(ma[c], v);
        md[c] = v & MODE_WMASK;
        rdc(ma[c], v & MODE_WMASK);
        chk("mode", rm[c], m[7:0]);
        wrt(xa[c], v);
        rdc(xa[c], v & MUX_WMASK);
        chk("sel", {ns[c], ps[c]}, {v[5:4], v[1:0]});
      end
      for (int k = 0; k < 8; k++) begin
        @(posedge clk);
        pl[c] <= 10'($random(seed));
        mi[c] <= 10'($random(seed));
        ren <= 1'($random(seed));
        step(c);
      end
      wrt(ca[c], cm[c]);
      rfm[c] = 1'b0;
      ffm[c] = 1'b0;
      rdc(ca[c], ectl(c));
      cm[c] = 8'h00;
      wrt(ca[c], 8'h00);
      step(c);
    end
    rdc(8'h55, 8'h00);
    chk("hit", hit, 8'h00);
    tally_and_finish();
  end
endmodule // dual_comparator_control_test
